/* File: include/pstd_pkg.sv */
// Package holding register map, field positions and constants of the PHY self-test block.
package pstd_pkg;

  // Register byte addresses; printed offsets are not all multiples of four, so index times four.
  localparam logic [7:0]  RX_ERR_COUNT_IDX   = 8'h15;
  localparam logic [7:0]  LOOP_CONTROL_IDX   = 8'h16;
  localparam logic [7:0]  TEST_STATUS_IDX    = 8'h17;
  localparam logic [11:0] RX_ERR_COUNT_ADDR  = {2'b00, RX_ERR_COUNT_IDX, 2'b00};
  localparam logic [11:0] LOOP_CONTROL_ADDR  = {2'b00, LOOP_CONTROL_IDX, 2'b00};
  localparam logic [11:0] TEST_STATUS_ADDR   = {2'b00, TEST_STATUS_IDX, 2'b00};

  // Control register field positions.
  localparam int CTL_COUNT_MODE_BIT  = 15;
  localparam int CTL_PRBS_SEL_BIT    = 14;
  localparam int CTL_SHORT_SIZE_BIT  = 13;
  localparam int CTL_GEN_EN_BIT      = 12;
  localparam int CTL_REV_FWD_BIT     = 7;
  localparam int CTL_MII_FWD_BIT     = 6;
  localparam int CTL_LOOP_MODE_LSB   = 2;
  localparam int CTL_PCS_LOOP_LSB    = 0;

  // Writable bits of the control register; bits 11:8 stay zero.
  localparam logic [15:0] CTL_WRITE_MASK     = 16'hF0FF;
  localparam logic [15:0] CTL_RESET          = 16'h0000;
  localparam logic [15:0] RX_ERR_COUNT_RESET = 16'h0000;
  localparam logic [15:0] RX_ERR_COUNT_MAX   = 16'hFFFF;

  // Status register field positions.
  localparam int STS_SYNC_BIT        = 11;
  localparam int STS_SYNC_LOST_BIT   = 10;
  localparam int STS_GEN_BUSY_BIT    = 9;
  localparam int STS_SCR_MASTER_BIT  = 8;
  localparam int STS_SCR_SLAVE_BIT   = 7;
  localparam int STS_POWER_BIT       = 6;

  // Loopback select one-hot codes.
  localparam logic [3:0] LOOP_REVERSE  = 4'h8;
  localparam logic [3:0] LOOP_EXTERNAL = 4'h4;
  localparam logic [3:0] LOOP_ANALOG   = 4'h2;
  localparam logic [3:0] LOOP_DIGITAL  = 4'h1;

  // Coding-sublayer loop point codes at 100 Mb/s.
  localparam logic [1:0] PCS_AFTER_MLT3    = 2'b11;
  localparam logic [1:0] PCS_AFTER_SCRAM   = 2'b10;
  localparam logic [1:0] PCS_BEFORE_SCRAM  = 2'b01;

  // Packet lengths in bytes.
  localparam logic [10:0] SHORT_PACKET_BYTES = 11'd64;
  localparam logic [10:0] LONG_PACKET_BYTES  = 11'd1518;

  // Constant payload byte of a single test packet.
  localparam logic [7:0]  CONST_PAYLOAD      = 8'hA5;
  localparam logic [15:0] PRBS_SEED          = 16'hFFFF;

  // Loop point decode; at most one loop-mode flag and one coding-sublayer flag set.
  typedef struct packed {
    logic reverse;
    logic external;
    logic analog;
    logic digital;
    logic pcs_after_mlt3;
    logic pcs_after_scram;
    logic pcs_before_scram;
    logic pcs_gig;
  } pstd_loop_type;

endpackage : pstd_pkg

/* File: design/pstd_selftest.sv */
// PHY self-test block: receive error tally, PRBS packet generator and checker, loopback select, status.
//
// Functional notes
// - Receive error tally is 16 bits and saturates at all ones.
// - Any write to the error count register clears it to zero, or to one if an error arrives in the same cycle.
// - Continuous mode: a full PRBS counter pulses and restarts from zero.
// - PRBS select with generator on sends PRBS packets; generator off keeps checker on.
// - PRBS select clear with generator on sends one constant packet, no PRBS.
// - Packets are 64 bytes with size bit set, 1518 bytes otherwise.
// - Generator runs only while its enable bit is one.
// - Reserved control and status bits ignore writes and read zero.
// - Reverse-loop forward bit settable only in reverse loop; gates RX to MAC.
// - MAC-loop forward bit settable only in MAC loop; gates looped data to line.
// - At 100 Mb/s codes 11, 10, 01 pick after MLT3, after scrambler, before scrambler.
// - At 1000 Mb/s a set low bit loops before gigabit signal processing.
// - Sync flag reads one while the checker is locked.
// - Sync-lost flag latches on loss of lock and clears on read.
// - Busy flag is one while the generator produces packets.
// - Master legacy scramble flag reflects the gigabit master coding state.
// - Slave legacy scramble flag reflects the gigabit slave coding state.
// - Power state bit reads one in normal power, zero when down or asleep.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module pstd_selftest #(
  parameter int PRBS_COUNT_W = 16,
  parameter int LOCK_GOOD    = 8,
  parameter int LOCK_BAD     = 4
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        rx_err_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        mac_loop_i,
  input  wire logic        speed_gig_i,
  input  wire logic        scr_master_legacy_i,
  input  wire logic        scr_slave_legacy_i,
  input  wire logic        core_power_normal_i,
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_last_o,
  output logic             prbs_wrap_pulse_o,
  output logic [7:0]       loop_point_o,
  output logic             rx_to_mac_en_o,
  output logic             tx_to_line_en_o
);

  // Refuse parameter values that the counters and the 8-bit lock run counters cannot hold.
  if (PRBS_COUNT_W < 2 || PRBS_COUNT_W > 32 || LOCK_GOOD < 1 || LOCK_GOOD > 255 ||
      LOCK_BAD < 1 || LOCK_BAD > 255) begin : g_param_check
    $error("pstd_selftest: parameter out of range");
  end

  typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_DONE} pstd_gen_type;

  typedef struct packed {
    logic [15:0]             err_count;
    logic [15:0]             ctl;
    logic                    sync;
    logic                    sync_lost;
    logic [7:0]              good_run;
    logic [7:0]              bad_run;
    logic [15:0]             chk_lfsr;
    logic [PRBS_COUNT_W-1:0] chk_count;
    logic [PRBS_COUNT_W-1:0] gen_count;
    pstd_gen_type            gen_state;
    logic [15:0]             gen_lfsr;
    logic [10:0]             byte_left;
    logic                    tx_valid;
    logic [7:0]              tx_data;
    logic                    tx_last;
    logic                    wrap_pulse;
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    pstd_pkg::pstd_loop_type loop;
    logic                    rx_fwd;
    logic                    tx_fwd;
    logic [5:0]              status_in;
  } pstd_state_type;

  pstd_state_type st;
  pstd_state_type next_st;

  // Status inputs from other clock domains pass two flip-flops first.
  logic [4:0] meta_sync;
  logic [4:0] stat_sync;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_sync <= 5'h0_0;
      stat_sync <= 5'h0_0;
    end else begin
      meta_sync <= {scr_master_legacy_i, scr_slave_legacy_i, core_power_normal_i, speed_gig_i, mac_loop_i};
      stat_sync <= meta_sync;
    end
  end

  // Next-state logic of the whole block.
  always_comb begin
    logic        access;
    logic        wr_err;
    logic        rd_sts;
    logic [15:0] wr_val;
    logic [15:0] gen_next_lfsr;
    logic [15:0] chk_next_lfsr;
    logic        chk_on;
    logic        gen_on;
    logic        match;
    logic [10:0] pkt_len;
    logic [3:0]  mode;
    logic [1:0]  pcs;
    logic        tick;
    access        = psel_i && penable_i && !st.pready;
    wr_err        = access && pwrite_i && paddr_i == pstd_pkg::RX_ERR_COUNT_ADDR;
    rd_sts        = access && !pwrite_i && paddr_i == pstd_pkg::TEST_STATUS_ADDR;
    wr_val        = pwdata_i[15:0];
    next_st       = st;
    next_st.pready     = access;
    next_st.pslverr    = 1'b0;
    next_st.wrap_pulse = 1'b0;
    next_st.status_in  = {stat_sync, 1'b0};

    // Register writes; reserved bits masked off, forward bits only in their loop mode.
    if (access && pwrite_i && paddr_i == pstd_pkg::LOOP_CONTROL_ADDR) begin
      next_st.ctl = wr_val & pstd_pkg::CTL_WRITE_MASK;
      if (wr_val[pstd_pkg::CTL_LOOP_MODE_LSB +: 4] != pstd_pkg::LOOP_REVERSE)
        next_st.ctl[pstd_pkg::CTL_REV_FWD_BIT] = 1'b0;
      if (!stat_sync[0])
        next_st.ctl[pstd_pkg::CTL_MII_FWD_BIT] = 1'b0;
    end
    if (access && !(paddr_i == pstd_pkg::RX_ERR_COUNT_ADDR || paddr_i == pstd_pkg::LOOP_CONTROL_ADDR ||
                    paddr_i == pstd_pkg::TEST_STATUS_ADDR))
      next_st.pslverr = 1'b1;

    // Read data mux; reserved bits read zero.
    next_st.prdata = 32'h0000_0000;
    if (access && !pwrite_i) begin
      case (paddr_i)
        pstd_pkg::RX_ERR_COUNT_ADDR: next_st.prdata = {16'h0000, st.err_count};
        pstd_pkg::LOOP_CONTROL_ADDR: next_st.prdata = {16'h0000, st.ctl};
        pstd_pkg::TEST_STATUS_ADDR: begin
          next_st.prdata[pstd_pkg::STS_SYNC_BIT]       = st.sync;
          next_st.prdata[pstd_pkg::STS_SYNC_LOST_BIT]  = st.sync_lost;
          next_st.prdata[pstd_pkg::STS_GEN_BUSY_BIT]   = st.gen_state == GEN_SEND;
          next_st.prdata[pstd_pkg::STS_SCR_MASTER_BIT] = st.status_in[5];
          next_st.prdata[pstd_pkg::STS_SCR_SLAVE_BIT]  = st.status_in[4];
          next_st.prdata[pstd_pkg::STS_POWER_BIT]      = st.status_in[3];
        end
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end

    // Receive error tally: write clears, otherwise count and saturate; an error beside the clear is kept.
    if (wr_err)
      next_st.err_count = {15'h0000, rx_err_i};
    else if (rx_err_i && st.err_count != pstd_pkg::RX_ERR_COUNT_MAX)
      next_st.err_count = st.err_count + 16'h0001;

    // Loop point decode.
    mode = st.ctl[pstd_pkg::CTL_LOOP_MODE_LSB +: 4];
    pcs  = st.ctl[pstd_pkg::CTL_PCS_LOOP_LSB +: 2];
    next_st.loop.reverse  = mode == pstd_pkg::LOOP_REVERSE;
    next_st.loop.external = mode == pstd_pkg::LOOP_EXTERNAL;
    next_st.loop.analog   = mode == pstd_pkg::LOOP_ANALOG;
    next_st.loop.digital  = mode == pstd_pkg::LOOP_DIGITAL;
    next_st.loop.pcs_after_mlt3   = !stat_sync[1] && pcs == pstd_pkg::PCS_AFTER_MLT3;
    next_st.loop.pcs_after_scram  = !stat_sync[1] && pcs == pstd_pkg::PCS_AFTER_SCRAM;
    next_st.loop.pcs_before_scram = !stat_sync[1] && pcs == pstd_pkg::PCS_BEFORE_SCRAM;
    next_st.loop.pcs_gig          = stat_sync[1] && pcs[0];
    next_st.rx_fwd = !next_st.loop.reverse || st.ctl[pstd_pkg::CTL_REV_FWD_BIT];
    next_st.tx_fwd = !stat_sync[0] || st.ctl[pstd_pkg::CTL_MII_FWD_BIT];

    // Packet generator.
    gen_on  = st.ctl[pstd_pkg::CTL_GEN_EN_BIT];
    pkt_len = st.ctl[pstd_pkg::CTL_SHORT_SIZE_BIT] ? pstd_pkg::SHORT_PACKET_BYTES
                                                    : pstd_pkg::LONG_PACKET_BYTES;
    // Both LFSRs step eight bits per byte, so a state is always the last two bytes of its stream.
    gen_next_lfsr = st.gen_lfsr;
    chk_next_lfsr = st.chk_lfsr;
    for (int i = 0; i < 8; i++) begin
      gen_next_lfsr = {gen_next_lfsr[14:0],
                       gen_next_lfsr[15] ^ gen_next_lfsr[13] ^ gen_next_lfsr[12] ^ gen_next_lfsr[10]};
      chk_next_lfsr = {chk_next_lfsr[14:0],
                       chk_next_lfsr[15] ^ chk_next_lfsr[13] ^ chk_next_lfsr[12] ^ chk_next_lfsr[10]};
    end
    tick = st.tx_valid && tx_ready_i;
    if (!gen_on) begin
      next_st.gen_state = GEN_IDLE;
      next_st.tx_valid  = 1'b0;
      next_st.tx_last   = 1'b0;
    end else begin
      case (st.gen_state)
        GEN_IDLE: begin
          next_st.gen_state = GEN_SEND;
          next_st.byte_left = pkt_len;
          next_st.tx_valid  = 1'b1;
          next_st.tx_data   = pstd_pkg::CONST_PAYLOAD;
          // PRBS packets continue the stream, so a locked checker sees no repeated byte at a packet start.
          if (st.ctl[pstd_pkg::CTL_PRBS_SEL_BIT]) begin
            next_st.gen_lfsr = gen_next_lfsr;
            next_st.tx_data  = gen_next_lfsr[7:0];
          end
          next_st.tx_last   = pkt_len == 11'd1;
        end
        GEN_SEND: begin
          if (tick) begin
            if (st.byte_left == 11'd1) begin
              next_st.tx_valid = 1'b0;
              next_st.tx_last  = 1'b0;
              // PRBS mode repeats packets; constant mode sends just one.
              next_st.gen_state = st.ctl[pstd_pkg::CTL_PRBS_SEL_BIT] ? GEN_IDLE : GEN_DONE;
            end else begin
              next_st.byte_left = st.byte_left - 11'd1;
              next_st.tx_last   = st.byte_left == 11'd2;
              next_st.gen_lfsr  = gen_next_lfsr;
              next_st.tx_data   = st.ctl[pstd_pkg::CTL_PRBS_SEL_BIT] ? gen_next_lfsr[7:0]
                                                                      : pstd_pkg::CONST_PAYLOAD;
              if (st.ctl[pstd_pkg::CTL_PRBS_SEL_BIT]) begin
                // Continuous counting: wrap to zero at the maximum, with a pulse only when the count mode bit is set.
                if (st.gen_count == {PRBS_COUNT_W{1'b1}}) begin
                  next_st.gen_count  = '0;
                  next_st.wrap_pulse = st.ctl[pstd_pkg::CTL_COUNT_MODE_BIT];
                end else begin
                  next_st.gen_count = st.gen_count + 1'b1;
                end
              end
            end
          end
        end
        GEN_DONE: next_st.gen_state = GEN_DONE;
        default:  next_st.gen_state = GEN_IDLE;
      endcase
    end

    // PRBS checker: self-synchronising, active whenever PRBS select is set.
    chk_on = st.ctl[pstd_pkg::CTL_PRBS_SEL_BIT];
    match = chk_next_lfsr[7:0] == rx_data_i;
    if (!chk_on) begin
      next_st.sync     = 1'b0;
      next_st.good_run = 8'h00;
      next_st.bad_run  = 8'h00;
    end else if (rx_valid_i) begin
      next_st.chk_lfsr = st.sync ? chk_next_lfsr : {st.chk_lfsr[7:0], rx_data_i};
      if (match) begin
        next_st.bad_run = 8'h00;
        if (!st.sync && st.good_run + 8'h01 >= 8'(LOCK_GOOD)) next_st.sync = 1'b1;
        else next_st.good_run = st.good_run + 8'h01;
        if (st.chk_count == {PRBS_COUNT_W{1'b1}}) begin
          next_st.chk_count  = '0;
          next_st.wrap_pulse = st.ctl[pstd_pkg::CTL_COUNT_MODE_BIT];
        end else begin
          next_st.chk_count = st.chk_count + 1'b1;
        end
      end else begin
        next_st.good_run = 8'h00;
        if (st.sync && st.bad_run + 8'h01 >= 8'(LOCK_BAD)) begin
          next_st.sync    = 1'b0;
          next_st.bad_run = 8'h00;
        end else begin
          next_st.bad_run = st.bad_run + 8'h01;
        end
      end
    end

    // Lock-lost flag: clears on status read, but a loss in the same cycle wins.
    if (rd_sts) next_st.sync_lost = 1'b0;
    if (st.sync && !next_st.sync) next_st.sync_lost = 1'b1;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st           <= '0;
      st.ctl       <= pstd_pkg::CTL_RESET;
      st.err_count <= pstd_pkg::RX_ERR_COUNT_RESET;
      st.gen_lfsr  <= pstd_pkg::PRBS_SEED;
      st.gen_state <= GEN_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign pready_o          = st.pready;
  assign prdata_o          = st.prdata;
  assign pslverr_o         = st.pslverr;
  assign tx_valid_o        = st.tx_valid;
  assign tx_data_o         = st.tx_data;
  assign tx_last_o         = st.tx_last;
  assign prbs_wrap_pulse_o = st.wrap_pulse;
  assign loop_point_o      = st.loop;
  assign rx_to_mac_en_o    = st.rx_fwd;
  assign tx_to_line_en_o   = st.tx_fwd;

  logic wr_err_d;

  // Count-register write taken one edge earlier, for the tally assertions.
  always_ff @(posedge clk_i) wr_err_d <= psel_i && penable_i && !st.pready && pwrite_i
                                         && paddr_i == pstd_pkg::RX_ERR_COUNT_ADDR;

  a_count_saturate: assert property (@(posedge clk_i) disable iff (srst_i)
    st.err_count == 16'hFFFF && !$past(wr_err_d) |=> st.err_count != 16'h0000 || wr_err_d)
    else $error("error tally wrapped");

  a_write_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_err_d |-> st.err_count <= 16'h0001)
    else $error("error tally not cleared by write");

  a_tally_step: assert property (@(posedge clk_i) disable iff (srst_i)
    !wr_err_d && !$past(rx_err_i) && !$past(srst_i) |-> st.err_count == $past(st.err_count))
    else $error("error tally moved without error");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    st.ctl[11:8] == 4'h0 && st.prdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  a_gen_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    !st.ctl[pstd_pkg::CTL_GEN_EN_BIT] |=> !st.tx_valid)
    else $error("generator ran while disabled");

  a_busy_valid: assert property (@(posedge clk_i) disable iff (srst_i)
    st.tx_valid |-> st.gen_state == GEN_SEND)
    else $error("data sent while generator idle");

  a_single_pkt: assert property (@(posedge clk_i) disable iff (srst_i)
    st.gen_state == GEN_DONE && st.ctl[pstd_pkg::CTL_GEN_EN_BIT] |=> st.gen_state == GEN_DONE && !st.tx_valid)
    else $error("constant packet repeated");

  a_lost_latch: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(st.sync) |-> st.sync_lost)
    else $error("lock loss not latched");

  a_rev_fwd: assert property (@(posedge clk_i) disable iff (srst_i)
    st.ctl[pstd_pkg::CTL_REV_FWD_BIT] |-> st.ctl[5:2] == pstd_pkg::LOOP_REVERSE ##0 1'b1)
    else $error("reverse forward bit outside reverse loop");

endmodule : pstd_selftest

/* File: dv/pstd_far_end.sv */
// Far-side model: byte sink for the test generator that loops accepted bytes back as the received stream.
`timescale 1ns/1ps

module pstd_far_end (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       slow_i,
  input  wire logic       corrupt_i,
  output logic            tx_ready_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o
);
  logic [2:0] phase;

  // Sink takes a byte every cycle, or one in eight while stalling.
  assign tx_ready_o = !srst_i && (!slow_i || phase == 3'd0);

  // Accepted bytes come back one cycle later; an idle line toggles so stale data never looks valid.
  always_ff @(posedge clk_i) begin
    phase      <= srst_i ? 3'd0 : phase + 3'd1;
    rx_valid_o <= !srst_i && tx_valid_i && tx_ready_o;
    if (srst_i) begin
      rx_data_o <= 8'h00;
    end else if (tx_valid_i && tx_ready_o) begin
      rx_data_o <= tx_data_i ^ (corrupt_i ? {phase, 5'h15} : 8'h00);
    end else begin
      rx_data_o <= ~rx_data_o;
    end
  end
endmodule : pstd_far_end

/* File: dv/test_pstd_selftest.sv */
// Self-checking testbench of the PHY self-test block over APB with a looping far-side model.
`timescale 1ns/1ps

module test_pstd_selftest;
  logic        clk_i, srst_i, psel, penable, pwrite, pready, pslverr, rx_err, rx_valid, mac_loop, gig;
  logic        scr_m, scr_s, pwr, tx_ready, tx_valid, tx_last, wrap, rx_fwd, tx_fwd, slow, corrupt, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, r, seed;
  logic [7:0]  rx_data, tx_data, loop_pt;
  logic [15:0] ec;
  logic [3:0]  code;
  int          err_count, n_compared, cur_len, last_len, pkts, nconst, wraps, n;

  pstd_selftest #(.PRBS_COUNT_W(4)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .rx_err_i(rx_err), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .mac_loop_i(mac_loop), .speed_gig_i(gig), .scr_master_legacy_i(scr_m), .scr_slave_legacy_i(scr_s),
    .core_power_normal_i(pwr), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_last_o(tx_last), .prbs_wrap_pulse_o(wrap), .loop_point_o(loop_pt), .rx_to_mac_en_o(rx_fwd),
    .tx_to_line_en_o(tx_fwd));

  pstd_far_end far_u (.clk_i(clk_i), .srst_i(srst_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .slow_i(slow), .corrupt_i(corrupt), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));

  // Clock of 25 ns period.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Packet monitor: byte count per packet, non-constant bytes and counter wrap pulses.
  always @(posedge clk_i) begin
    if (wrap === 1'b1) wraps++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      cur_len++;
      if (tx_data !== pstd_pkg::CONST_PAYLOAD) nconst++;
      if (tx_last === 1'b1) begin
        last_len = cur_len;
        cur_len = 0;
        pkts++;
      end
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic end_sim;
    $display("mismatches %0d of %0d compared", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_pkts(input int k, input int lim);
    n = 0;
    while (pkts < k && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      end_sim();
    end
  endtask : wait_pkts

  initial begin
    {psel, penable, pwrite, rx_err, mac_loop, gig, scr_m, scr_s, pwr, slow, corrupt} = '0;
    paddr = '0;
    ec = '0;
    pwdata = '0;
    seed = 32'd65788;
    srst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(0, pstd_pkg::RX_ERR_COUNT_ADDR, 0);
    chk(r, pstd_pkg::RX_ERR_COUNT_RESET);
    apb(0, pstd_pkg::LOOP_CONTROL_ADDR, 0);
    chk(r, pstd_pkg::CTL_RESET);
    apb(1, pstd_pkg::TEST_STATUS_ADDR, 32'hFFFF_FFFF);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r, 32'h0000_0000);
    apb(0, 12'h060, 0);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    // Error tally: random run length, clear by write, then saturation.
    n = xs() % 20 + 1;
    rx_err <= 1'b1;
    repeat (n) @(posedge clk_i);
    rx_err <= 1'b0;
    apb(0, pstd_pkg::RX_ERR_COUNT_ADDR, 0);
    chk(r, n);
    apb(1, pstd_pkg::RX_ERR_COUNT_ADDR, xs());
    apb(0, pstd_pkg::RX_ERR_COUNT_ADDR, 0);
    chk(r, 32'h0000_0000);
    rx_err <= 1'b1;
    repeat (65540) @(posedge clk_i);
    rx_err <= 1'b0;
    apb(0, pstd_pkg::RX_ERR_COUNT_ADDR, 0);
    chk(r, {16'h0000, pstd_pkg::RX_ERR_COUNT_MAX});
    // Loop select, forwarding bits and status inputs over every loop code.
    for (int i = 0; i < 32; i++) begin
      d = xs();
      d[12] = 1'b0;
      code = 4'h8 >> (i % 4);
      d[5:2] = code;
      {mac_loop, gig, scr_m, scr_s, pwr} <= d[24:20];
      apb(1, pstd_pkg::LOOP_CONTROL_ADDR, {16'h0000, ec & 16'hFFFC});
      apb(1, pstd_pkg::LOOP_CONTROL_ADDR, d);
      repeat (4) @(posedge clk_i);
      apb(0, pstd_pkg::LOOP_CONTROL_ADDR, 0);
      ec = d[15:0] & pstd_pkg::CTL_WRITE_MASK;
      if (code != 4'h8) ec[7] = 1'b0;
      if (!mac_loop) ec[6] = 1'b0;
      chk(r, {16'h0000, ec});
      chk(loop_pt, {code, !gig && d[1:0] == 2'b11, !gig && d[1:0] == 2'b10, !gig && d[1:0] == 2'b01,
        gig && d[0]});
      chk(rx_fwd, code == 4'h8 ? ec[7] : 1'b1);
      chk(tx_fwd, mac_loop ? ec[6] : 1'b1);
      apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
      chk(r, {23'h00_0000, scr_m, scr_s, pwr, 6'h00});
    end
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 0);
    // Constant mode, short packet: one packet only, busy while sending.
    pkts = 0;
    nconst = 0;
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 32'h0000_B000);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[9], 1'b1);
    wait_pkts(1, 500);
    chk(last_len, 64);
    chk(nconst, 0);
    repeat (200) @(posedge clk_i);
    chk(pkts, 1);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[9], 1'b0);
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 0);
    // Long packet with a stalling sink.
    pkts = 0;
    slow <= 1'b1;
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 32'h0000_9000);
    wait_pkts(1, 15000);
    chk(last_len, 1518);
    slow <= 1'b0;
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 0);
    // Enable cleared in mid-packet stops the generator.
    pkts = 0;
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 32'h0000_9000);
    repeat (20) @(posedge clk_i);
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 32'h0000_8000);
    repeat (2) @(posedge clk_i);
    chk(tx_valid, 1'b0);
    repeat (100) @(posedge clk_i);
    chk(pkts, 0);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[9], 1'b0);
    // PRBS packets looped back: lock, counter wraps, loss of lock latched until read.
    pkts = 0;
    nconst = 0;
    cur_len = 0;
    wraps = 0;
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 32'h0000_F000);
    wait_pkts(4, 2000);
    chk(last_len, 64);
    chk(nconst > 0, 1'b1);
    chk(wraps > 0, 1'b1);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[11:9], 3'b101);
    corrupt <= 1'b1;
    repeat (60) @(posedge clk_i);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[11:10], 2'b01);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[11:10], 2'b00);
    corrupt <= 1'b0;
    repeat (300) @(posedge clk_i);
    apb(0, pstd_pkg::TEST_STATUS_ADDR, 0);
    chk(r[11], 1'b1);
    apb(1, pstd_pkg::LOOP_CONTROL_ADDR, 0);
    end_sim();
  end
endmodule : test_pstd_selftest
